// >>> csb_pkg.sv
// Shared constants for the code security and boot select block
package csb_pkg;

  // ==========================================================
  // Register map: word index, byte address is index times four
  // ==========================================================
  localparam logic [15:0] IDX_CTRL     = 16'h0000; // Programming mode and erase-all
  localparam logic [15:0] IDX_ISPCTL   = 16'h0001; // In-system programming control view
  localparam logic [15:0] IDX_COMPANY  = 16'h0002; // Manufacturer identification
  localparam logic [15:0] IDX_DEVICE   = 16'h0003; // Device identification
  localparam logic [15:0] IDX_SETTINGS = 16'hFFFF; // Top of loader space
  localparam int          ADR_W        = 18;       // Byte address width
  localparam int          IDX_LSB      = 2;        // Word index starts here

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CTRL_PROG_BIT   = 0; // Memory programming mode active
  localparam int CTRL_ERASE_BIT  = 1; // Write 1 to erase all settings
  localparam int ISP_FORCED_BIT  = 7; // Forced loader boot running
  localparam int ISP_LOCKED_BIT  = 6; // Lock in force
  localparam int ISP_PROG_BIT    = 0; // Programming mode mirror
  localparam int SET_LOCK_BIT    = 0; // 0 locks code, settings and identification access
  localparam int SET_INHIBIT_BIT = 1; // 0 restricts table reads
  localparam int SET_ENCRYPT_BIT = 2; // 0 enables port 0 encoding
  localparam int SET_GAIN_BIT    = 7; // 0 halves oscillator gain

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [7:0]  SET_ERASED = 8'hFF;       // Erased settings byte
  localparam logic [31:0] WORD_ZERO  = 32'h00000000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;

  // Arbitrary identification values, not those of any real part
  localparam logic [7:0] COMPANY_ID_VAL = 8'hA5;
  localparam logic [7:0] DEVICE_ID_VAL  = 8'h3C;
  // Arbitrary port 0 encoding key
  localparam logic [7:0] ENCODE_KEY     = 8'h5A;

endpackage

// >>> csb_set_if.sv
// Carrier between the bus logic and the settings store
`timescale 1ns/100ps
interface csb_set_if;
  logic       wrEn;     // One-cycle program request
  logic       eraseAll; // One-cycle erase-all request
  logic [7:0] wrData;   // Byte to program
  logic [7:0] settings; // Current settings byte

  modport ctrl  (output wrEn, output eraseAll, output wrData, input settings);
  modport store (input wrEn, input eraseAll, input wrData, output settings);
endinterface

// >>> csb_settings_store.sv
// One-way security settings byte; erase-all and reset both reload all 1s
`timescale 1ns/100ps
module csb_settings_store (
  input  wire logic   clk,
  input  wire logic   rst_n,
  csb_set_if.store    setIf
);

  logic [7:0] set_q; // Stored settings
  logic [7:0] set_d; // Next settings

  // ==========================================================
  // Next value
  // ==========================================================
  // Programming can only pull bits low; erase wins over a write
  always_comb begin
    set_d = set_q;
    if (setIf.eraseAll) begin
      set_d = csb_pkg::SET_ERASED; // RL7 RL15
    end else if (setIf.wrEn) begin
      set_d = set_q & setIf.wrData; // RL6
    end
  end

  // Register only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      set_q <= csb_pkg::SET_ERASED;
    end else begin
      set_q <= set_d;
    end
  end

  assign setIf.settings = set_q;

endmodule

// >>> csb_top.sv
// Code protection, table-read guard and forced loader boot select
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/100ps

// Notes on behaviour
// RL1: both boot keys low force loader boot
// RL2: force pin low forces loader boot
// RL3: default boot application, forced boot loader
// RL4: ISP control bit 7 shows forced boot
// RL5: programming mode blocks special setting registers
// RL6: settings bits only go from 1 to 0; reset here returns them all to 1
// RL7: only erase-all returns settings to 1; reset here also reloads 8'hFF
// RL8: identification registers fixed, never writable
// RL9: settings byte at top of loader space
// RL10: lock 0 refuses code and setting access
// RL11: inhibit 0: external table reads stay external
// RL12: internal table reads always reach everything
// RL13: inhibit 1: table reads unrestricted
// RL14: encryption on encodes port 0 data
// RL15: encryption cleared only by whole erase; reset here clears it too
// RL16: gain bit 0 halves oscillator gain
// RL17: straps sampled in reset, held until next
module csb_top (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  // Wishbone classic slave
  input  wire logic                        wb_cyc_i,
  input  wire logic                        wb_stb_i,
  input  wire logic                        wb_we_i,
  input  wire logic [csb_pkg::ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                  wb_sel_i,
  input  wire logic [31:0]                 wb_dat_i,
  output logic      [31:0]                 wb_dat_o,
  output logic                             wb_ack_o,
  // Boot strap pins
  input  wire logic                        bootForcePin,
  input  wire logic                        bootKeyB,
  input  wire logic                        bootKeyA,
  // Core table-read request
  input  wire logic                        tableReadActive,
  input  wire logic                        tableReadFromInternal,
  input  wire logic                        tableReadTargetInternal,
  // Port 0 data from the core
  input  wire logic [7:0]                  port0DataIn,
  // Results
  output logic                             bootFromLoader,
  output logic                             codeAccessAllowed,
  output logic                             tableReadToInternal,
  output logic      [7:0]                  port0DataOut,
  output logic                             gainReduce
);

  // ==========================================================
  // Declarations
  // ==========================================================
  logic [2:0]  strapMeta;     // First synchroniser stage
  logic [2:0]  strapSync;     // Second stage, safe to read
  logic        strapForced;   // Decoded strap request
  logic        boot_q;        // Latched boot selection
  logic        boot_d;
  logic        prog_q;        // Programming mode
  logic        prog_d;
  logic        ack_q;         // Bus answer
  logic        ack_d;
  logic [31:0] dat_q;         // Bus read data
  logic [31:0] dat_d;
  logic        access_q;      // Code access allowed
  logic        access_d;
  logic        tread_q;       // Table read goes internal
  logic        tread_d;
  logic [7:0]  p0_q;          // Port 0 output
  logic [7:0]  p0_d;
  logic        gain_q;        // Gain reduce output
  logic        gain_d;
  logic        busReq;        // New bus request this cycle
  logic [15:0] regIdx;        // Word index of the access
  logic        lockOn;        // Lock bit programmed
  logic        specialOpen;   // Special registers reachable
  logic [7:0]  encoded;       // Encoder result
  logic [7:0]  settings;      // Current settings byte

  csb_set_if setIf ();

  // ==========================================================
  // Settings store
  // ==========================================================
  csb_settings_store uStore (
    .clk   (clk),
    .rst_n (rst_n),
    .setIf (setIf.store)
  );

  assign settings = setIf.settings;
  assign lockOn   = ~settings[csb_pkg::SET_LOCK_BIT];
  // Special registers shut while programming or once locked
  assign specialOpen = ~prog_q & ~lockOn; // RL5 RL10

  // ==========================================================
  // Strap synchroniser
  // ==========================================================
  // No reset so the straps travel through while reset is held
  always_ff @(posedge clk) begin
    strapMeta <= {bootForcePin, bootKeyB, bootKeyA};
    strapSync <= strapMeta;
  end

  // Either key pair low or force pin low selects the loader
  assign strapForced = (~strapSync[1] & ~strapSync[0]) // RL1
                     | ~strapSync[2];                  // RL2

  // ==========================================================
  // Boot selection
  // ==========================================================
  // Tracks the straps during reset and freezes at release
  always_comb begin
    boot_d = boot_q; // RL17
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      boot_q <= strapForced; // RL17 RL3
    end else begin
      boot_q <= boot_d;
    end
  end

  // ==========================================================
  // Wishbone slave
  // ==========================================================
  assign busReq = wb_cyc_i & wb_stb_i & ~ack_q;
  assign regIdx = wb_adr_i[csb_pkg::ADR_W-1:csb_pkg::IDX_LSB];

  // Decode, read mux and write side effects
  always_comb begin
    ack_d          = busReq;
    dat_d          = dat_q;
    prog_d         = prog_q;
    setIf.wrEn     = 1'b0;
    setIf.eraseAll = 1'b0;
    setIf.wrData   = wb_dat_i[7:0];
    if (busReq && wb_we_i && wb_sel_i[0]) begin
      case (regIdx)
        csb_pkg::IDX_CTRL: begin
          prog_d         = wb_dat_i[csb_pkg::CTRL_PROG_BIT];
          // Erase-all stays reachable even when locked
          setIf.eraseAll = wb_dat_i[csb_pkg::CTRL_ERASE_BIT]; // RL7
        end
        csb_pkg::IDX_SETTINGS: begin
          setIf.wrEn = specialOpen; // RL9 RL5 RL10
        end
        // Identification and ISP view ignore writes
        default: begin
          prog_d = prog_q; // RL8
        end
      endcase
    end
    if (busReq) begin
      dat_d = csb_pkg::WORD_ZERO;
      if (!wb_we_i) begin
        case (regIdx)
          csb_pkg::IDX_CTRL: begin
            dat_d[csb_pkg::CTRL_PROG_BIT] = prog_q;
          end
          csb_pkg::IDX_ISPCTL: begin
            dat_d[csb_pkg::ISP_FORCED_BIT] = boot_q; // RL4
            dat_d[csb_pkg::ISP_LOCKED_BIT] = lockOn;
            dat_d[csb_pkg::ISP_PROG_BIT]   = prog_q;
          end
          csb_pkg::IDX_COMPANY: begin
            // Blocked reads return zero
            dat_d[7:0] = specialOpen ? csb_pkg::COMPANY_ID_VAL // RL8
                                     : csb_pkg::BYTE_ZERO;     // RL5
          end
          csb_pkg::IDX_DEVICE: begin
            dat_d[7:0] = specialOpen ? csb_pkg::DEVICE_ID_VAL  // RL8
                                     : csb_pkg::BYTE_ZERO;     // RL5
          end
          csb_pkg::IDX_SETTINGS: begin
            dat_d[7:0] = specialOpen ? settings : csb_pkg::BYTE_ZERO; // RL9 RL10
          end
          // Unmapped reads answer zero
          default: begin
            dat_d = csb_pkg::WORD_ZERO;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Port 0 encoder
  // ==========================================================
  // A fixed XOR key is cheap; it deters casual probing only
  assign encoded = port0DataIn ^ csb_pkg::ENCODE_KEY;

  // ==========================================================
  // Protection outputs
  // ==========================================================
  always_comb begin
    access_d = ~lockOn; // RL10
    // Internal callers see all; outside callers need inhibit high
    tread_d  = tableReadActive & tableReadTargetInternal
             & (tableReadFromInternal                       // RL12
                | settings[csb_pkg::SET_INHIBIT_BIT]);      // RL11 RL13
    p0_d     = settings[csb_pkg::SET_ENCRYPT_BIT] ? port0DataIn
                                                  : encoded; // RL14
    gain_d   = ~settings[csb_pkg::SET_GAIN_BIT]; // RL16
  end

  // ==========================================================
  // State registers
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_q   <= 1'b0;
      ack_q    <= 1'b0;
      dat_q    <= csb_pkg::WORD_ZERO;
      access_q <= 1'b0;
      tread_q  <= 1'b0;
      p0_q     <= csb_pkg::BYTE_ZERO;
      gain_q   <= 1'b0;
    end else begin
      prog_q   <= prog_d;
      ack_q    <= ack_d;
      dat_q    <= dat_d;
      access_q <= access_d;
      tread_q  <= tread_d;
      p0_q     <= p0_d;
      gain_q   <= gain_d;
    end
  end

  // Outputs straight from flops
  assign wb_ack_o            = ack_q;
  assign wb_dat_o            = dat_q;
  assign bootFromLoader      = boot_q;
  assign codeAccessAllowed   = access_q;
  assign tableReadToInternal = tread_q;
  assign port0DataOut        = p0_q;
  assign gainReduce          = gain_q;

endmodule

// >>> csb_top_asserts.sv
// Port-level checks for the security and boot select block
`timescale 1ns/100ps
module csb_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_we_i,
  input wire logic [17:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic bootForcePin,
  input wire logic bootKeyB,
  input wire logic bootKeyA,
  input wire logic tableReadActive,
  input wire logic tableReadFromInternal,
  input wire logic tableReadTargetInternal,
  input wire logic bootFromLoader,
  input wire logic codeAccessAllowed,
  input wire logic tableReadToInternal,
  input wire logic gainReduce
);
  // ==========================================================
  // Clocking; the strap checks run inside reset on purpose
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Erase-all taken on the bus this edge; it may legally bring bits back to 1
  logic eraseTaken;
  assign eraseTaken = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
                    && (wb_adr_i[17:2] == 16'h0000) && wb_dat_i[1];
  // Four reset edges cover the two sync stages plus the capture
  sequence sForceHeld;
    (!rst_n && (!bootForcePin || (!bootKeyA && !bootKeyB)))[*4];
  endsequence
  sequence sAppHeld;
    (!rst_n && bootForcePin && (bootKeyA || bootKeyB))[*4];
  endsequence
  a_boot_forced: assert property (disable iff (1'b0) sForceHeld |=> bootFromLoader)
    else $error("forced boot not selected");
  a_boot_default: assert property (disable iff (1'b0) sAppHeld |=> !bootFromLoader)
    else $error("application boot not selected");
  a_boot_held: assert property ($past(rst_n) |-> $stable(bootFromLoader))
    else $error("boot selection moved outside reset");
  // The output lags the settings by one cycle, so an erase one edge back excuses a change
  a_lock_oneway: assert property ($past(rst_n) && !codeAccessAllowed && !$past(eraseTaken)
    |=> !codeAccessAllowed)
    else $error("lock came back without erase");
  a_gain_oneway: assert property ($past(rst_n) && gainReduce && !$past(eraseTaken)
    |=> gainReduce)
    else $error("gain reduction dropped without erase");
  a_table_internal: assert property (tableReadActive && tableReadFromInternal
    && tableReadTargetInternal |=> tableReadToInternal) else $error("internal read refused");
  a_table_idle: assert property (!tableReadActive |=> !tableReadToInternal)
    else $error("table route without a read");
  a_ack_single: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle pulse");
endmodule
bind csb_top csb_chk csb_chk_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .bootForcePin(bootForcePin),
  .bootKeyB(bootKeyB), .bootKeyA(bootKeyA), .tableReadActive(tableReadActive),
  .tableReadFromInternal(tableReadFromInternal), .gainReduce(gainReduce),
  .tableReadTargetInternal(tableReadTargetInternal), .bootFromLoader(bootFromLoader),
  .codeAccessAllowed(codeAccessAllowed), .tableReadToInternal(tableReadToInternal));

// >>> csb_prog_model.sv
// Device programmer model: classic bus master for the settings registers
`timescale 1ns/100ps
module csb_prog_model (
  input  wire logic                      clk,
  input  wire logic                      ack,
  input  wire logic [31:0]               datIn,
  output logic                           cyc,
  output logic                           stb,
  output logic                           we,
  output logic [csb_pkg::ADR_W-1:0]      adr,
  output logic [3:0]                     sel,
  output logic [31:0]                    dat
);
  // Bus idle at time zero
  initial begin
    {cyc, stb, we, sel} = 7'h00;
    adr = 18'h00000;
    dat = 32'h00000000;
  end
  // One cycle; waits for ack with no assumed latency
  task automatic xfer(input logic w, input logic [17:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    {cyc, stb, we, sel} <= {2'b11, w, 4'hF};
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = datIn;
    // Released lines show the inverse so nothing leans on stale values
    {cyc, stb} <= 2'b00;
    adr <= ~a;
    dat <= ~d;
  endtask
endmodule

// >>> csb_tb.sv
// Self-checking bench for the security and boot select block
`timescale 1ns/100ps
module tb;
  logic clk, rst_n, cyc, stb, we, ack, forcePin, keyB, keyA, trAct, trFrom, trTgt;
  logic bootLd, codeOk, trInt, gainRed;
  logic [17:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, q;
  logic [7:0]  p0In, p0Out;
  int          errTotal, totalChecks, cycCount;
  csb_top csb_top_inst (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .bootForcePin(forcePin), .bootKeyB(keyB), .bootKeyA(keyA),
    .tableReadActive(trAct), .tableReadFromInternal(trFrom), .tableReadTargetInternal(trTgt),
    .port0DataIn(p0In), .bootFromLoader(bootLd), .codeAccessAllowed(codeOk),
    .tableReadToInternal(trInt), .port0DataOut(p0Out), .gainReduce(gainRed));
  csb_prog_model csb_prog_model_inst (.clk(clk), .ack(ack), .datIn(rdat), .cyc(cyc),
    .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat));
  always #25 clk = ~clk;
  // Hang guard, far above the roughly 140 cycles the run needs
  always @(posedge clk) begin
    cycCount <= cycCount + 1;
    if (cycCount == 3000) begin
      errTotal++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    csb_prog_model_inst.xfer(1'b1, a, {24'h000000, d}, q);
  endtask
  task automatic rdc(input logic [17:0] a, input logic [31:0] exp);
    csb_prog_model_inst.xfer(1'b0, a, 32'h00000000, q);
    chk(q, exp);
  endtask
  // Straps in reset, then moved afterwards to show the choice sticks
  task automatic boot_case(input logic [2:0] s, input logic exp);
    @(posedge clk);
    rst_n <= 1'b0;
    {forcePin, keyB, keyA} <= s;
    tick(5);
    rst_n <= 1'b1;
    tick(2);
    rdc(18'h00004, {24'h000000, exp, 7'h00});
    {forcePin, keyB, keyA} <= ~s;
    tick(4);
    chk({31'h0, bootLd}, {31'h0, exp});
  endtask
  task automatic t_ids();
    wr(18'h00008, 8'h00);
    rdc(18'h00008, {24'h0, csb_pkg::COMPANY_ID_VAL});
    rdc(18'h0000C, {24'h0, csb_pkg::DEVICE_ID_VAL});
    rdc(18'h00010, 32'h0);
  endtask
  task automatic t_settings();
    chk({24'h0, p0Out}, {24'h0, p0In});
    rdc(18'h3FFFC, 32'hFF);
    wr(18'h3FFFC, 8'h7F);
    tick(2);
    chk({31'h0, gainRed}, 32'h1);
    wr(18'h3FFFC, 8'hFF);
    rdc(18'h3FFFC, 32'h7F);
    wr(18'h3FFFC, 8'hFB);
    tick(2);
    chk({24'h0, p0Out}, {24'h0, p0In ^ csb_pkg::ENCODE_KEY});
  endtask
  // Table read with {active, from internal, target internal}
  task automatic tr(input logic [2:0] s, input logic exp);
    @(posedge clk);
    {trAct, trFrom, trTgt} <= s;
    tick(2);
    chk({31'h0, trInt}, {31'h0, exp});
  endtask
  task automatic t_prog();
    wr(18'h00000, 8'h01);
    rdc(18'h3FFFC, 32'h0);
    rdc(18'h00008, 32'h0);
    wr(18'h3FFFC, 8'h00);
    wr(18'h00000, 8'h00);
    rdc(18'h3FFFC, 32'h79);
  endtask
  task automatic t_lock_erase();
    wr(18'h3FFFC, 8'hFE);
    tick(2);
    chk({31'h0, codeOk}, 32'h0);
    rdc(18'h3FFFC, 32'h0);
    wr(18'h00000, 8'h02);
    tick(2);
    rdc(18'h3FFFC, 32'hFF);
    chk({22'h0, codeOk, gainRed, p0Out}, {22'h0, 2'b10, p0In});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    {clk, rst_n, forcePin, keyB, keyA, trAct, trFrom, trTgt} = 8'h38;
    p0In = 8'h3C;
    {errTotal, totalChecks, cycCount} = {32'h0, 32'h0, 32'h0};
    boot_case(3'b111, 1'b0);
    boot_case(3'b100, 1'b1);
    boot_case(3'b110, 1'b0);
    boot_case(3'b011, 1'b1);
    t_ids();
    t_settings();
    tr(3'b101, 1'b1);
    wr(18'h3FFFC, 8'hFD);
    tr(3'b101, 1'b0);
    tr(3'b111, 1'b1);
    tr(3'b011, 1'b0);
    t_prog();
    t_lock_erase();
    conclude();
  end
endmodule
